// ==== rtl/usart_defs.svh ====
// Register offsets, command bits, field positions and reset values of the serial engine
`ifndef USART_DEFS_SVH
`define USART_DEFS_SVH

// Register byte offsets
`define USART_OFF_CTRL   8'h00
`define USART_OFF_MODE   8'h04
`define USART_OFF_STAT   8'h08
`define USART_OFF_THR    8'h0C
`define USART_OFF_RHR    8'h10
`define USART_OFF_GUARD  8'h14
`define USART_OFF_IDLE   8'h18
`define USART_OFF_DIV    8'h1C

// Control register command bits
`define USART_CR_CLR     0
`define USART_CR_SEND_ADDRESS_CMD   1
`define USART_CR_WAIT    2
`define USART_CR_RELOAD  3

// Mode register fields
`define USART_MR_PAR_LSB 0
`define USART_MR_PAR_MSB 2
`define USART_MR_LEN_LSB 3
`define USART_MR_LEN_MSB 4

// Status register bits
`define USART_SR_FREE    0
`define USART_SR_IDLE    1
`define USART_SR_RXRDY   2
`define USART_SR_CHECK_BIT_ERROR_FLAG    3
`define USART_SR_FRAME   4
`define USART_SR_TOUT    5
`define USART_SR_BRK     6
`define USART_SR_OVR     7

// Reset values
`define USART_PAR_RST    3'h4
`define USART_LEN_RST    2'h3
`define USART_GUARD_RST  8'h00
`define USART_IDLE_RST   16'h0000
`define USART_DIV_RST    16'h0010

`endif

// ==== rtl/usart_pkg.sv ====
// Types shared by the serial engine modules
package usart_pkg;

    // Check bit modes of the mode register
    typedef enum logic [2:0] {
        PAR_EVEN   = 3'b000,
        PAR_ODD    = 3'b001,
        PAR_SPACE  = 3'b010,
        PAR_MARK   = 3'b011,
        PAR_NONE   = 3'b100,
        PAR_NONE_B = 3'b101,
        PAR_DROP_A = 3'b110,
        PAR_DROP_B = 3'b111
    } check_bit_e;

    typedef enum logic [2:0] {
        TX_IDLE   = 3'b000,
        TX_START  = 3'b001,
        TX_DATA   = 3'b010,
        TX_PARITY = 3'b011,
        TX_STOP   = 3'b100,
        TX_GUARD  = 3'b101
    } tx_state_e;

    typedef enum logic [2:0] {
        RX_IDLE   = 3'b000,
        RX_START  = 3'b001,
        RX_DATA   = 3'b010,
        RX_PARITY = 3'b011,
        RX_STOP   = 3'b100
    } rx_state_e;

    // Whole state of the engine
    typedef struct packed {
        logic        rxMeta;
        logic        rxSync;
        logic        wrPend;
        logic [7:0]  wrAddr;
        logic [31:0] rdata;
        check_bit_e  parSel;
        logic [1:0]  chrLen;
        logic [7:0]  guard;
        logic [15:0] idleVal;
        logic [15:0] div;
        tx_state_e   txSt;
        logic [7:0]  thr;
        logic        thrFull;
        logic        thrAddr;
        logic        sendArm;
        logic [7:0]  txShift;
        logic [2:0]  txBitCnt;
        logic        txPar;
        logic [7:0]  guardCnt;
        logic        txd;
        rx_state_e   rxSt;
        logic        rxArmed;
        logic [15:0] rxCnt;
        logic [2:0]  rxBitCnt;
        logic [7:0]  rxShift;
        logic        rxPar;
        logic [7:0]  rhr;
        logic        rxRdy;
        logic        parErr;
        logic        frmErr;
        logic        brk;
        logic        ovr;
        logic [15:0] toCnt;
        logic        toRun;
        logic        toFlag;
    } engine_s;

    // State of the bit period divider
    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } bit_clock_s;

endpackage

// ==== rtl/usart_bit_clock.sv ====
// Bit period tick generator driven by the programmed divisor
`timescale 1ns/100ps
`include "usart_defs.svh"
module usart_bit_clock (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Divisor in clocks per bit
    input  wire logic [15:0] div,
    // One clock pulse per bit period
    output logic             bitTick
);

    usart_pkg::bit_clock_s s_q;
    usart_pkg::bit_clock_s s_d;

    // Count down, reload and pulse at zero
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == 16'h0000) begin
            s_d.cnt = div - 16'h0001;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt - 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bitTick = s_q.tick;

endmodule

// ==== rtl/usart_char_engine.sv ====
// Serial character engine: parity, multidrop, timeguard, idle time-out, framing
//
// Notes on behaviour
// - Mode register check bit select picks five parity modes and multidrop.
// - Even parity: bit is one when data holds odd ones; mismatch flagged.
// - Odd parity: bit is one when data ones are even; mismatch flagged.
// - Mark parity sends one; received zero is an error.
// - Space parity sends zero; received one is an error.
// - No parity: no check bit sent, no parity error ever.
// - Parity error flag sticks until the clear flags command.
// - Check bit select codes six and seven give multidrop operation.
// - Multidrop: data sent with check bit zero, address with one.
// - Multidrop receiver flags parity error when check bit is high.
// - Send address command marks the next written byte as an address.
// - Bytes written without that command go as data, check bit zero.
// - Guard period zero adds no idle time between characters.
// - Nonzero guard holds line high that many bit periods after stop.
// - Holding register stays busy through guard; frees at next start bit.
// - Transmitter idle flag stays low until guard time ends.
// - Idle delay zero disables time-out; flag stays zero.
// - 16-bit idle counter loads delay, counts bit periods, reloads per character.
// - Counter reaching zero raises the time-out flag.
// - Wait command stops the counter until a new character arrives.
// - Reload command restarts the counter at once from the delay.
// - Stop bit sampled low sets framing error at mid stop bit.
// - All-zero character with low stop is a break, not framing error.
`timescale 1ns/100ps
`include "usart_defs.svh"
module usart_char_engine (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Serial lines
    input  wire logic        rxd,
    output logic             txd
);

    usart_pkg::engine_s s_q;
    usart_pkg::engine_s s_d;
    logic               bitTick;
    logic               addrPhase;
    logic               ctrlWr;
    logic               clrCmd;
    logic               launch;
    logic               charDone;
    logic               stopLow;
    logic               isBreak;
    logic               hasPar;
    logic               txIdle;
    logic [2:0]         lastBit;

    // Ones count over the configured data bits only
    function automatic logic ones_odd(input logic [7:0] data, input logic [1:0] len);
        logic [7:0] mask;
        mask = 8'hFF >> (2'd3 - len);
        return ^(data & mask);
    endfunction

    // Check bit value for a character in the given mode
    function automatic logic check_bit(input usart_pkg::check_bit_e mode,
                                       input logic [7:0] data,
                                       input logic [1:0] len,
                                       input logic addr);
        logic ones;
        ones = ones_odd(data, len);
        case (mode)
            usart_pkg::PAR_EVEN:   return ones;
            usart_pkg::PAR_ODD:    return ~ones;
            usart_pkg::PAR_MARK:   return 1'b1;
            usart_pkg::PAR_SPACE:  return 1'b0;
            usart_pkg::PAR_DROP_A,
            usart_pkg::PAR_DROP_B: return addr;
            default:               return 1'b0;
        endcase
    endfunction

    usart_bit_clock u_bit_clock (
        .mclk    (mclk),
        .arst_n  (arst_n),
        .div     (s_q.div),
        .bitTick (bitTick)
    );

    // Whole next-state logic
    always_comb begin
        s_d = s_q;
        launch = 1'b0;
        charDone = 1'b0;
        stopLow = 1'b0;
        isBreak = 1'b0;
        hasPar = (s_q.parSel != usart_pkg::PAR_NONE) && (s_q.parSel != usart_pkg::PAR_NONE_B);
        lastBit = 3'd4 + {1'b0, s_q.chrLen};
        txIdle = (s_q.txSt == usart_pkg::TX_IDLE) && !s_q.thrFull;

        // Receive line synchroniser
        s_d.rxMeta = rxd;
        s_d.rxSync = s_q.rxMeta;

        // Bus address phase capture
        addrPhase = hsel && htrans[1] && hready;
        s_d.wrPend = addrPhase && hwrite;
        if (addrPhase) begin
            s_d.wrAddr = haddr;
        end
        ctrlWr = s_q.wrPend && (s_q.wrAddr == `USART_OFF_CTRL);
        clrCmd = ctrlWr && hwdata[`USART_CR_CLR];

        // Register writes in the data phase
        if (s_q.wrPend && s_q.wrAddr == `USART_OFF_MODE) begin
            s_d.parSel = usart_pkg::check_bit_e'(hwdata[`USART_MR_PAR_MSB:`USART_MR_PAR_LSB]);
            s_d.chrLen = hwdata[`USART_MR_LEN_MSB:`USART_MR_LEN_LSB];
        end else if (s_q.wrPend && s_q.wrAddr == `USART_OFF_GUARD) begin
            s_d.guard = hwdata[7:0];
        end else if (s_q.wrPend && s_q.wrAddr == `USART_OFF_IDLE) begin
            s_d.idleVal = hwdata[15:0];
        end else if (s_q.wrPend && s_q.wrAddr == `USART_OFF_DIV) begin
            s_d.div = hwdata[15:0];
        end else if (s_q.wrPend && s_q.wrAddr == `USART_OFF_THR && !s_q.thrFull) begin
            s_d.thr = hwdata[7:0];
            s_d.thrFull = 1'b1;
            s_d.thrAddr = s_q.sendArm;
            s_d.sendArm = 1'b0;
        end
        if (ctrlWr && hwdata[`USART_CR_SEND_ADDRESS_CMD]) begin
            s_d.sendArm = 1'b1;
        end

        // Error flags clear first so that a same-cycle set wins
        if (clrCmd) begin
            s_d.parErr = 1'b0;
            s_d.frmErr = 1'b0;
            s_d.brk = 1'b0;
            s_d.ovr = 1'b0;
        end

        // Register reads, answered in the data phase
        if (addrPhase && !hwrite) begin
            // Setup reads see a write landing in this same cycle
            if (haddr == `USART_OFF_MODE) begin
                s_d.rdata = {27'h0, s_d.chrLen, s_d.parSel};
            end else if (haddr == `USART_OFF_STAT) begin
                s_d.rdata = 32'h0;
                s_d.rdata[`USART_SR_FREE] = !s_q.thrFull;
                s_d.rdata[`USART_SR_IDLE] = txIdle;
                s_d.rdata[`USART_SR_RXRDY] = s_q.rxRdy;
                s_d.rdata[`USART_SR_CHECK_BIT_ERROR_FLAG] = s_q.parErr;
                s_d.rdata[`USART_SR_FRAME] = s_q.frmErr;
                s_d.rdata[`USART_SR_TOUT] = s_q.toFlag;
                s_d.rdata[`USART_SR_BRK] = s_q.brk;
                s_d.rdata[`USART_SR_OVR] = s_q.ovr;
            end else if (haddr == `USART_OFF_RHR) begin
                s_d.rdata = {24'h0, s_q.rhr};
                s_d.rxRdy = 1'b0;
            end else if (haddr == `USART_OFF_GUARD) begin
                s_d.rdata = {24'h0, s_d.guard};
            end else if (haddr == `USART_OFF_IDLE) begin
                s_d.rdata = {16'h0, s_d.idleVal};
            end else if (haddr == `USART_OFF_DIV) begin
                s_d.rdata = {16'h0, s_d.div};
            end else begin
                s_d.rdata = 32'h0;
            end
        end

        // Transmitter, one step per bit period
        if (bitTick) begin
            case (s_q.txSt)
                usart_pkg::TX_IDLE: begin
                    launch = s_q.thrFull;
                end
                usart_pkg::TX_START: begin
                    s_d.txd = s_q.txShift[0];
                    s_d.txShift = {1'b0, s_q.txShift[7:1]};
                    s_d.txBitCnt = 3'd0;
                    s_d.txSt = usart_pkg::TX_DATA;
                end
                usart_pkg::TX_DATA: begin
                    if (s_q.txBitCnt == lastBit) begin
                        if (hasPar) begin
                            s_d.txd = s_q.txPar;
                            s_d.txSt = usart_pkg::TX_PARITY;
                        end else begin
                            s_d.txd = 1'b1;
                            s_d.txSt = usart_pkg::TX_STOP;
                        end
                    end else begin
                        s_d.txd = s_q.txShift[0];
                        s_d.txShift = {1'b0, s_q.txShift[7:1]};
                        s_d.txBitCnt = s_q.txBitCnt + 3'd1;
                    end
                end
                usart_pkg::TX_PARITY: begin
                    s_d.txd = 1'b1;
                    s_d.txSt = usart_pkg::TX_STOP;
                end
                usart_pkg::TX_STOP: begin
                    if (s_q.guard != 8'h00) begin
                        s_d.guardCnt = s_q.guard;
                        s_d.txSt = usart_pkg::TX_GUARD;
                    end else begin
                        launch = s_q.thrFull;
                        s_d.txSt = usart_pkg::TX_IDLE;
                    end
                end
                usart_pkg::TX_GUARD: begin
                    if (s_q.guardCnt == 8'h01) begin
                        launch = s_q.thrFull;
                        s_d.txSt = usart_pkg::TX_IDLE;
                    end else begin
                        s_d.guardCnt = s_q.guardCnt - 8'h01;
                    end
                end
                default: begin
                    s_d.txSt = usart_pkg::TX_IDLE;
                end
            endcase
        end
        // Start bit moves the holding register into the shifter
        if (launch) begin
            s_d.txSt = usart_pkg::TX_START;
            s_d.txd = 1'b0;
            s_d.txShift = s_q.thr;
            s_d.thrFull = 1'b0;
            s_d.txPar = check_bit(s_q.parSel, s_q.thr, s_q.chrLen, s_q.thrAddr);
        end

        // Receiver, sampled at mid bit
        if (s_q.rxSync) begin
            s_d.rxArmed = 1'b1;
        end
        if (s_q.rxSt == usart_pkg::RX_IDLE) begin
            if (s_q.rxArmed && !s_q.rxSync) begin
                s_d.rxCnt = {1'b0, s_q.div[15:1]};
                s_d.rxSt = usart_pkg::RX_START;
            end
        end else if (s_q.rxCnt != 16'h0000) begin
            s_d.rxCnt = s_q.rxCnt - 16'h0001;
        end else begin
            s_d.rxCnt = s_q.div - 16'h0001;
            case (s_q.rxSt)
                usart_pkg::RX_START: begin
                    s_d.rxShift = 8'h00;
                    s_d.rxBitCnt = 3'd0;
                    s_d.rxSt = s_q.rxSync ? usart_pkg::RX_IDLE : usart_pkg::RX_DATA;
                end
                usart_pkg::RX_DATA: begin
                    s_d.rxShift[s_q.rxBitCnt] = s_q.rxSync;
                    s_d.rxBitCnt = s_q.rxBitCnt + 3'd1;
                    s_d.rxPar = 1'b0;
                    if (s_q.rxBitCnt == lastBit) begin
                        s_d.rxSt = hasPar ? usart_pkg::RX_PARITY : usart_pkg::RX_STOP;
                    end
                end
                usart_pkg::RX_PARITY: begin
                    s_d.rxPar = s_q.rxSync;
                    s_d.rxSt = usart_pkg::RX_STOP;
                end
                default: begin
                    charDone = 1'b1;
                    stopLow = !s_q.rxSync;
                    s_d.rxArmed = s_q.rxSync;
                    s_d.rxSt = usart_pkg::RX_IDLE;
                end
            endcase
        end
        // Character completion and its error flags
        if (charDone) begin
            isBreak = stopLow && (s_q.rxShift == 8'h00) && !s_q.rxPar;
            if (isBreak) begin
                s_d.brk = 1'b1;
            end else begin
                if (stopLow) begin
                    s_d.frmErr = 1'b1;
                end
                if (s_q.parSel == usart_pkg::PAR_DROP_A || s_q.parSel == usart_pkg::PAR_DROP_B) begin
                    s_d.parErr = s_d.parErr | s_q.rxPar;
                end else if (hasPar) begin
                    s_d.parErr = s_d.parErr |
                        (s_q.rxPar != check_bit(s_q.parSel, s_q.rxShift, s_q.chrLen, 1'b0));
                end
                s_d.ovr = s_d.ovr | s_d.rxRdy;
                s_d.rhr = s_q.rxShift;
                s_d.rxRdy = 1'b1;
            end
        end

        // Idle time-out counter
        if (ctrlWr && hwdata[`USART_CR_WAIT]) begin
            s_d.toRun = 1'b0;
            s_d.toFlag = 1'b0;
        end
        if (ctrlWr && hwdata[`USART_CR_RELOAD]) begin
            s_d.toCnt = s_q.idleVal;
            s_d.toRun = 1'b1;
            s_d.toFlag = bitTick && s_q.toRun && (s_q.toCnt <= 16'h0001); // Expiry beats clear
        end else if (charDone) begin
            s_d.toCnt = s_q.idleVal;
            s_d.toRun = 1'b1;
        end else if (bitTick && s_q.toRun) begin
            if (s_q.toCnt <= 16'h0001) begin
                s_d.toCnt = 16'h0000;
                s_d.toRun = 1'b0;
                s_d.toFlag = 1'b1;
            end else begin
                s_d.toCnt = s_q.toCnt - 16'h0001;
            end
        end
        if (s_q.idleVal == 16'h0000) begin
            s_d.toRun = 1'b0;
            s_d.toFlag = 1'b0;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.rxMeta <= 1'b1;
            s_q.rxSync <= 1'b1;
            s_q.txd <= 1'b1;
            s_q.parSel <= usart_pkg::check_bit_e'(`USART_PAR_RST);
            s_q.chrLen <= `USART_LEN_RST;
            s_q.guard <= `USART_GUARD_RST;
            s_q.idleVal <= `USART_IDLE_RST;
            s_q.div <= `USART_DIV_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;
    assign txd = s_q.txd;

    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    property p_mark_tx;
        (s_q.txSt == usart_pkg::TX_PARITY) && (s_q.parSel == usart_pkg::PAR_MARK) |-> txd;
    endproperty
    a_mark_tx: assert property (p_mark_tx)
        else $error("mark check bit not high");

    property p_space_tx;
        (s_q.txSt == usart_pkg::TX_PARITY) && (s_q.parSel == usart_pkg::PAR_SPACE) |-> !txd;
    endproperty
    a_space_tx: assert property (p_space_tx)
        else $error("space check bit not low");

    property p_no_par;
        $rose(s_q.parErr) |-> $past(hasPar);
    endproperty
    a_no_par: assert property (p_no_par)
        else $error("parity error with parity off");

    property p_par_sticky;
        s_q.parErr && !clrCmd |=> s_q.parErr;
    endproperty
    a_par_sticky: assert property (p_par_sticky)
        else $error("parity error lost without clear");

    property p_guard_high;
        s_q.txSt == usart_pkg::TX_GUARD |-> txd && !txIdle;
    endproperty
    a_guard_high: assert property (p_guard_high)
        else $error("line low or idle during guard");

    property p_free_at_start;
        $fell(s_q.thrFull) |-> (s_q.txSt == usart_pkg::TX_START) && !txd;
    endproperty
    a_free_at_start: assert property (p_free_at_start)
        else $error("holding register freed off start bit");

    property p_tout_off;
        (s_q.idleVal == 16'h0000) && $past(s_q.idleVal == 16'h0000) |-> !s_q.toFlag;
    endproperty
    a_tout_off: assert property (p_tout_off)
        else $error("time-out with idle delay zero");

    property p_frame_set;
        charDone && stopLow && !isBreak |=> s_q.frmErr;
    endproperty
    a_frame_set: assert property (p_frame_set)
        else $error("framing error not flagged");

    property p_break_no_frame;
        charDone && isBreak && !s_q.frmErr && !clrCmd |=> s_q.brk && !s_q.frmErr;
    endproperty
    a_break_no_frame: assert property (p_break_no_frame)
        else $error("break flagged as framing error");

endmodule

// ==== tb/serial_peer.sv ====
// Remote serial station that drives rxd and captures frames from txd
`timescale 1ns/100ps
module serial_peer #(
    parameter int BITC = 4
) (
    // Clock
    input  wire logic mclk,
    // Serial lines
    input  wire logic txd,
    output logic      rxd
);
    int cyc = 0;
    int lastT = 0;

    // Line idles high; free cycle count for gap timing
    initial rxd = 1'b1;
    always @(posedge mclk) cyc <= cyc + 1;

    // Sends n bits LSB first, then idles high
    task automatic send(input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            rxd <= f[i];
            repeat (BITC) @(posedge mclk);
        end
        rxd <= 1'b1;
        repeat (3 * BITC) @(posedge mclk);
    endtask

    // Samples n bits mid-bit from a falling edge; returns at the last bit
    task automatic grab(input int n, output logic [11:0] f, output int gap);
        f = '0;
        do @(posedge mclk); while (txd !== 1'b0);
        gap = cyc - lastT;
        lastT = cyc;
        repeat (BITC / 2) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            f[i] = txd;
            if (i < n - 1) repeat (BITC) @(posedge mclk);
        end
    endtask
endmodule

// ==== tb/usart_char_engine_test.sv ====
// Self-checking bench for the serial character engine
`timescale 1ns/100ps
`include "usart_defs.svh"
module usart_char_engine_test;
    logic        mclk, arst_n, hsel, hwrite, hreadyout, hresp, rxd, txd;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, r;
    int          nFail, nTests;
    logic [7:0]  ra [7] = '{`USART_OFF_MODE, `USART_OFF_STAT, `USART_OFF_GUARD,
                           `USART_OFF_IDLE, `USART_OFF_DIV, `USART_OFF_CTRL, 8'h20};
    logic [31:0] rv [7] = '{32'h1C, 32'h3, 32'h0, 32'h0, 32'h10, 32'h0, 32'h0};

    // Engine with hready looped from its own hreadyout, and the remote station
    usart_char_engine uut (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rxd(rxd), .txd(txd));
    serial_peer #(.BITC(4)) peer (.mclk(mclk), .txd(txd), .rxd(rxd));

    // Clock and watchdog
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;
    initial begin
        repeat (20000) @(posedge mclk);
        nFail++;
        report_and_stop();
    end

    task automatic report_and_stop();
        if (nFail == 0 && nTests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        nTests++;
        if (g !== e) begin
            nFail++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // One bus transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask

    // Sends one byte and compares the frame seen on txd
    task automatic txChk(input logic [7:0] md, input logic sa, input logic [7:0] d,
                         input int n, input logic [11:0] e);
        logic [11:0] f;
        int          g;
        wr(`USART_OFF_MODE, {24'h0, md});
        if (sa) wr(`USART_OFF_CTRL, 32'h2);
        fork
            peer.grab(n, f, g);
            wr(`USART_OFF_THR, {24'h0, d});
        join
        chk("txFrame", {20'h0, e}, {20'h0, f});
    endtask

    // Two bytes back to back; start spacing and status inside the guard
    task automatic gapChk(input logic [7:0] gd, input int e);
        logic [11:0] f;
        int          g;
        repeat (8) @(posedge mclk); // Let the previous stop bit end
        wr(`USART_OFF_GUARD, {24'h0, gd});
        fork
            begin
                peer.grab(11, f, g);
                peer.grab(11, f, g);
            end
            begin
                wr(`USART_OFF_THR, 32'h5A);
                repeat (6) @(posedge mclk);
                wr(`USART_OFF_THR, 32'hA5);
                repeat (40) @(posedge mclk);
                rd(`USART_OFF_STAT);
                chk("txStat", {31'h0, gd == 8'h0}, r & 32'h3);
            end
        join
        chk("gap", e, g);
    endtask

    // Receives one frame; compares status flags and held data
    task automatic rxChk(input logic [7:0] md, input logic clr, input logic [11:0] f,
                         input int n, input logic [31:0] e);
        wr(`USART_OFF_MODE, {24'h0, md});
        if (clr) wr(`USART_OFF_CTRL, 32'h1);
        peer.send(f, n);
        rd(`USART_OFF_STAT);
        chk("rxStat", e, r & 32'h5C);
        rd(`USART_OFF_RHR);
        if (e[2]) chk("rhr", {24'h0, f[8:1]}, r);
    endtask

    task automatic toChk(input int w, input logic e);
        repeat (w) @(posedge mclk);
        rd(`USART_OFF_STAT);
        chk("timeout", {31'h0, e}, {31'h0, r[5]});
    endtask

    // Main sequence
    initial begin
        arst_n = 1'b0;
        hsel = 1'b1;
        htrans = 2'h0;
        haddr = 8'h00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        nFail = 0;
        nTests = 0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        chk("txdIdle", 32'h1, {31'h0, txd});
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("hreadyout", 32'h1, {31'h0, hreadyout});
        for (int i = 0; i < 7; i++) begin
            rd(ra[i]);
            chk("resetVal", rv[i], r);
        end
        wr(`USART_OFF_GUARD, 32'hFFFF_FFFF);
        rd(`USART_OFF_GUARD);
        chk("guardWidth", 32'hFF, r);
        wr(`USART_OFF_GUARD, 32'h0);
        wr(`USART_OFF_DIV, 32'h4);
        for (int m = 0; m < 6; m++) begin
            txChk(8'h18 | 8'(m), 1'b0, 8'h41, (m < 4) ? 11 : 10, (m < 4) ?
                {1'b1, (m == 1 || m == 3), 8'h41, 1'b0} : {2'b01, 8'h41, 1'b0});
        end
        txChk(8'h00, 1'b0, 8'h23, 8, 12'h086);
        txChk(8'h1E, 1'b0, 8'h55, 11, 12'h4AA);
        txChk(8'h1F, 1'b1, 8'hAA, 11, 12'h754);
        txChk(8'h1F, 1'b0, 8'h0F, 11, 12'h41E);
        gapChk(8'h0, 44);
        gapChk(8'h5, 64);
        rxChk(8'h18, 1'b1, 12'h482, 11, 32'h04);
        rxChk(8'h18, 1'b1, 12'h682, 11, 32'h0C);
        rxChk(8'h18, 1'b0, 12'h482, 11, 32'h0C);
        rxChk(8'h19, 1'b1, 12'h482, 11, 32'h0C);
        rxChk(8'h19, 1'b1, 12'h682, 11, 32'h04);
        rxChk(8'h1A, 1'b1, 12'h682, 11, 32'h0C);
        rxChk(8'h1B, 1'b1, 12'h482, 11, 32'h0C);
        rxChk(8'h1B, 1'b1, 12'h682, 11, 32'h04);
        rxChk(8'h1C, 1'b1, 12'h282, 10, 32'h04);
        rxChk(8'h1E, 1'b1, 12'h682, 11, 32'h0C);
        rxChk(8'h1F, 1'b1, 12'h482, 11, 32'h04);
        rxChk(8'h18, 1'b1, 12'h082, 11, 32'h14);
        rxChk(8'h18, 1'b1, 12'h000, 11, 32'h40);
        rxChk(8'h18, 1'b1, 12'h482, 11, 32'h04);
        wr(`USART_OFF_IDLE, 32'hA);
        wr(`USART_OFF_CTRL, 32'h8);
        toChk(32, 1'b0);
        toChk(16, 1'b1);
        wr(`USART_OFF_CTRL, 32'h4);
        toChk(60, 1'b0);
        peer.send(12'h482, 11);
        toChk(0, 1'b0);
        toChk(40, 1'b1);
        wr(`USART_OFF_IDLE, 32'h0);
        wr(`USART_OFF_CTRL, 32'h8);
        toChk(60, 1'b0);
        report_and_stop();
    end
endmodule
